// ===== logic/hall_pattern_switch.sv
// Purpose: Multi-channel pattern switching with Hall pattern evaluation
// Assumes: All inputs synchronous to pclk; timer events are one-cycle pulses
// Notes:   APB slave answers in the first access cycle
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module hall_pattern_switch
  import hall_mcm_pkg::*;
#(
  parameter int DT_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [2:0]        position_input,
  input  wire logic              aux_period_match,
  input  wire logic              aux_zero_match,
  input  wire logic              aux_compare_match,
  input  wire logic              main_period_match,
  input  wire logic              main_one_match,
  input  wire logic              main_zero_match,
  input  wire logic              channel1_compare_match,
  input  wire logic              count_direction,
  output logic      [5:0]        active_output_pattern,
  output logic                   hall_compare_ready,
  output logic                   correct_hall_event,
  output logic                   wrong_hall_event,
  output logic                   pattern_shadow_transfer,
  output logic                   main_pwm_blocked
);

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  function automatic logic switch_event(input logic [2:0] sel, input logic che,
    input logic apm, input logic mom, input logic c61, input logic mpm,
    input logic dir);
    unique case (sel)
      SW_HALL:       switch_event = che;
      SW_AUX_PM:     switch_event = apm;
      SW_MAIN_OM_DN: switch_event = mom & (dir != DIR_UP);
      SW_CH1_UP:     switch_event = c61 & (dir == DIR_UP);
      SW_MAIN_PM_UP: switch_event = mpm & (dir == DIR_UP);
      default:       switch_event = 1'b0;
    endcase
  endfunction : switch_event

  function automatic logic hall_trigger(input logic [2:0] sel, input logic edge_seen,
    input logic acm, input logic apm, input logic mpm, input logic mom,
    input logic c61, input logic dir);
    unique case (sel)
      HS_EDGE:       hall_trigger = edge_seen;
      HS_AUX_CM:     hall_trigger = acm;
      HS_AUX_PM:     hall_trigger = apm;
      HS_OFF:        hall_trigger = 1'b0;
      HS_MAIN_PM_UP: hall_trigger = mpm & (dir == DIR_UP);
      HS_MAIN_OM_DN: hall_trigger = mom & (dir != DIR_UP);
      HS_CH1_UP:     hall_trigger = c61 & (dir == DIR_UP);
      HS_CH1_DN:     hall_trigger = c61 & (dir != DIR_UP);
    endcase
  endfunction : hall_trigger

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ctrl_type         ctrl, next_ctrl;
  logic [DT_W-1:0]  dead_time_value, next_dead_time_value;
  pattern_type      shadow, next_shadow;
  pattern_type      active, next_active;
  status_type       status, next_status;
  logic [2:0]       prev_pos, next_prev_pos;
  logic [DT_W-1:0]  dt_count, next_dt_count;
  logic             dt_busy, next_dt_busy;
  logic             ready_q, next_ready_q;
  logic             che_q, next_che_q;
  logic             whe_q, next_whe_q;
  logic             st_q, next_st_q;
  logic [31:0]      next_prdata;
  logic             next_pready;
  logic             next_pslverr;

  logic             wr_en;
  logic             rd_en;
  logic             delay_mode;
  logic             trig;
  logic             sw_evt;
  logic             sw_req;
  logic             hp_req;
  logic             do_transfer;
  logic             is_correct;
  logic             is_wrong;
  pattern_type      wr_pat;
  status_type       wr_clr;

  assign wr_en  = psel & penable & pready & pwrite;
  assign rd_en  = psel & ~penable & ~pwrite;
  assign wr_pat = pattern_type'(pwdata);
  assign wr_clr = status_type'(pwdata);
  assign sw_req = wr_en && paddr == SHADOW_OFFSET && wr_pat.pattern_transfer_request;
  assign hp_req = wr_en && paddr == SHADOW_OFFSET && wr_pat.hall_transfer_request;
  assign delay_mode = ctrl.channel_mode_select0 == MODE_HALL
                   && ctrl.channel_mode_select1 == MODE_HALL
                   && ctrl.channel_mode_select2 == MODE_HALL
                   && !ctrl.delay_bypass;
  assign trig = hall_trigger(ctrl.hall_sync_select, position_input != prev_pos,
                  aux_compare_match, aux_period_match, main_period_match,
                  main_one_match, channel1_compare_match, count_direction);
  assign is_correct = ready_q && position_input == active.expected_hall_pattern;
  assign is_wrong   = ready_q && position_input != active.expected_hall_pattern
                   && position_input != active.current_hall_pattern;
  assign sw_evt = switch_event(ctrl.switch_event_select, is_correct,
                  aux_period_match, main_one_match, channel1_compare_match,
                  main_period_match, count_direction);

  // ----------------------------------------------------------------
  // Switching and transfer
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ctrl.switch_sync_select)
      SYNC_DIRECT:  do_transfer = sw_evt | sw_req | status.reminder;
      SYNC_AUX_ZM:  do_transfer = (status.reminder | sw_evt | sw_req) & aux_zero_match;
      SYNC_MAIN_ZM: do_transfer = (status.reminder | sw_evt | sw_req) & main_zero_match;
      default:      do_transfer = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Hall evaluation next state
  // ----------------------------------------------------------------
  always_comb begin
    next_prev_pos = position_input;
    next_dt_busy  = dt_busy;
    next_dt_count = dt_count;
    next_ready_q  = 1'b0;
    if (delay_mode) begin
      if (trig) begin
        next_dt_busy  = 1'b1;
        next_dt_count = dead_time_value;
      end else if (dt_busy) begin
        if (dt_count == '0) begin
          next_dt_busy = 1'b0;
          next_ready_q = 1'b1;
        end else begin
          next_dt_count = dt_count - 1'b1;
        end
      end
    end else begin
      next_dt_busy = 1'b0;
      next_ready_q = trig;
    end
    next_che_q = is_correct;
    next_whe_q = is_wrong;
    next_st_q  = do_transfer;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_pos <= '0;
      dt_busy  <= 1'b0;
      dt_count <= '0;
      ready_q  <= 1'b0;
      che_q    <= 1'b0;
      whe_q    <= 1'b0;
      st_q     <= 1'b0;
    end else begin
      prev_pos <= next_prev_pos;
      dt_busy  <= next_dt_busy;
      dt_count <= next_dt_count;
      ready_q  <= next_ready_q;
      che_q    <= next_che_q;
      whe_q    <= next_whe_q;
      st_q     <= next_st_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers and APB next state
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl            = ctrl;
    next_dead_time_value = dead_time_value;
    next_shadow          = shadow;
    next_active          = active;
    next_status          = status;
    next_status.delay_mode = delay_mode;
    if (ready_q) begin
      next_status.sampled_hall = position_input;
    end
    if (wr_en) begin
      unique case (paddr)
        CTRL_OFFSET:     next_ctrl = ctrl_type'(pwdata);
        DEADTIME_OFFSET: next_dead_time_value = pwdata[DT_W-1:0];
        SHADOW_OFFSET: begin
          next_shadow.output_pattern        = wr_pat.output_pattern;
          next_shadow.current_hall_pattern  = wr_pat.current_hall_pattern;
          next_shadow.expected_hall_pattern = wr_pat.expected_hall_pattern;
        end
        STATUS_OFFSET: begin
          if (wr_clr.transfer_status_flag) next_status.transfer_status_flag = 1'b0;
          if (wr_clr.correct_hall) next_status.correct_hall = 1'b0;
          if (wr_clr.wrong_hall)   next_status.wrong_hall = 1'b0;
        end
        default: ;
      endcase
    end
    if (is_correct || hp_req) begin
      next_active.current_hall_pattern  = next_shadow.current_hall_pattern;
      next_active.expected_hall_pattern = next_shadow.expected_hall_pattern;
    end
    if (sw_evt || sw_req) begin
      next_status.reminder = 1'b1;
    end
    if (do_transfer) begin
      next_active.output_pattern = next_shadow.output_pattern;
      next_status.reminder = 1'b0;
      next_status.transfer_status_flag = 1'b1;
    end
    if (is_correct) next_status.correct_hall = 1'b1;
    if (is_wrong)   next_status.wrong_hall   = 1'b1;
    next_pready  = psel & ~penable;
    next_pslverr = 1'b0;
    next_prdata  = prdata;
    if (psel & ~penable) begin
      next_pslverr = 1'b1;
      next_prdata  = '0;
      unique case (paddr)
        CTRL_OFFSET:     begin next_pslverr = 1'b0; if (rd_en) next_prdata = ctrl; end
        DEADTIME_OFFSET: begin
          next_pslverr = 1'b0;
          if (rd_en) next_prdata = 32'(dead_time_value);
        end
        SHADOW_OFFSET:   begin next_pslverr = 1'b0; if (rd_en) next_prdata = shadow; end
        ACTIVE_OFFSET:   begin next_pslverr = 1'b0; if (rd_en) next_prdata = active; end
        STATUS_OFFSET:   begin next_pslverr = 1'b0; if (rd_en) next_prdata = status; end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl            <= ctrl_type'(CTRL_RESET);
      dead_time_value <= DEADTIME_RESET[DT_W-1:0];
      shadow          <= pattern_type'(PATTERN_RESET);
      active          <= pattern_type'(PATTERN_RESET);
      status          <= '0;
      prdata          <= '0;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
    end else begin
      ctrl            <= next_ctrl;
      dead_time_value <= next_dead_time_value;
      shadow          <= next_shadow;
      active          <= next_active;
      status          <= next_status;
      prdata          <= next_prdata;
      pready          <= next_pready;
      pslverr         <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign active_output_pattern   = active.output_pattern;
  assign hall_compare_ready      = ready_q;
  assign correct_hall_event      = che_q;
  assign wrong_hall_event        = whe_q;
  assign pattern_shadow_transfer = st_q;
  assign main_pwm_blocked        = status.delay_mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_sw_direct: assert property (@(posedge pclk) disable iff (!presetn)
    sw_req && ctrl.switch_sync_select == SYNC_DIRECT |=> pattern_shadow_transfer)
    else $error("direct software request did not transfer");
  chk_aux_sync: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.switch_sync_select == SYNC_AUX_ZM && do_transfer |-> aux_zero_match)
    else $error("aux sync transfer without zero-match");
  chk_sync_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.switch_sync_select == 2'h3 |-> !do_transfer)
    else $error("reserved sync code transferred");
  chk_pattern_copy: assert property (@(posedge pclk) disable iff (!presetn)
    do_transfer |=> active_output_pattern == $past(next_shadow.output_pattern))
    else $error("output pattern not copied from shadow");
  chk_hall_copy: assert property (@(posedge pclk) disable iff (!presetn)
    is_correct |=> active.expected_hall_pattern == $past(next_shadow.expected_hall_pattern))
    else $error("hall patterns not copied on correct event");
  chk_wrong_class: assert property (@(posedge pclk) disable iff (!presetn)
    ready_q && position_input != active.current_hall_pattern
      && position_input != active.expected_hall_pattern |=> wrong_hall_event)
    else $error("wrong hall event not flagged");
  chk_spike_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    ready_q && position_input == active.current_hall_pattern
      && position_input != active.expected_hall_pattern |=> !correct_hall_event && !wrong_hall_event)
    else $error("spike produced a hall event");
  chk_status_set: assert property (@(posedge pclk) disable iff (!presetn)
    do_transfer |=> status.transfer_status_flag && !status.reminder || $past(sw_evt))
    else $error("transfer did not set status flag");
  chk_hs_off: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.hall_sync_select == HS_OFF && !delay_mode |=> !hall_compare_ready)
    else $error("sampling ran while disabled");
  chk_edge_ready: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.hall_sync_select == HS_EDGE && !delay_mode && position_input != prev_pos
      |=> hall_compare_ready)
    else $error("edge did not raise compare ready");
  chk_delay_len: assert property (@(posedge pclk) disable iff (!presetn)
    delay_mode && trig && dead_time_value == 8'h02 ##1 (delay_mode && !trig)[*3]
      |=> hall_compare_ready)
    else $error("delay length wrong");
  chk_event_none: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.switch_event_select == SW_NONE |-> !sw_evt)
    else $error("event detected with no selection");

endmodule : hall_pattern_switch

// ===== pkg/hall_mcm_pkg.sv
// Purpose: Constants and carriers for the Hall pattern switch block
// Assumes: 32-bit APB, byte addresses, one word per register
// Notes:   Reserved fields read as zero, except in the control register, which keeps the values written to them
package hall_mcm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W          = 8;
  localparam logic [7:0] CTRL_OFFSET     = 8'h00;
  localparam logic [7:0] DEADTIME_OFFSET = 8'h04;
  localparam logic [7:0] SHADOW_OFFSET   = 8'h08;
  localparam logic [7:0] ACTIVE_OFFSET   = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET   = 8'h10;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] pad3;
    logic [3:0] channel_mode_select2;
    logic [3:0] channel_mode_select1;
    logic [3:0] channel_mode_select0;
    logic [2:0] pad2;
    logic       delay_bypass;
    logic       pad1;
    logic [2:0] hall_sync_select;
    logic [1:0] pad0b;
    logic [1:0] switch_sync_select;
    logic       pad0;
    logic [2:0] switch_event_select;
  } ctrl_type;

  typedef struct packed {
    logic [13:0] pad1;
    logic        hall_transfer_request;
    logic        pattern_transfer_request;
    logic [1:0]  pad0b;
    logic [2:0]  expected_hall_pattern;
    logic [2:0]  current_hall_pattern;
    logic [1:0]  pad0;
    logic [5:0]  output_pattern;
  } pattern_type;

  typedef struct packed {
    logic [23:0] pad;
    logic        delay_mode;
    logic        wrong_hall;
    logic        correct_hall;
    logic        transfer_status_flag;
    logic        reminder;
    logic [2:0]  sampled_hall;
  } status_type;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET     = 32'h0000_1000;
  localparam logic [31:0] PATTERN_RESET  = 32'h0000_0000;
  localparam logic [31:0] DEADTIME_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SW_NONE        = 3'h0;
  localparam logic [2:0] SW_HALL        = 3'h1;
  localparam logic [2:0] SW_AUX_PM      = 3'h2;
  localparam logic [2:0] SW_MAIN_OM_DN  = 3'h3;
  localparam logic [2:0] SW_CH1_UP      = 3'h4;
  localparam logic [2:0] SW_MAIN_PM_UP  = 3'h5;
  localparam logic [1:0] SYNC_DIRECT    = 2'h0;
  localparam logic [1:0] SYNC_AUX_ZM    = 2'h1;
  localparam logic [1:0] SYNC_MAIN_ZM   = 2'h2;
  localparam logic [2:0] HS_EDGE        = 3'h0;
  localparam logic [2:0] HS_AUX_CM      = 3'h1;
  localparam logic [2:0] HS_AUX_PM      = 3'h2;
  localparam logic [2:0] HS_OFF         = 3'h3;
  localparam logic [2:0] HS_MAIN_PM_UP  = 3'h4;
  localparam logic [2:0] HS_MAIN_OM_DN  = 3'h5;
  localparam logic [2:0] HS_CH1_UP      = 3'h6;
  localparam logic [2:0] HS_CH1_DN      = 3'h7;
  localparam logic [3:0] MODE_HALL      = 4'h8;
  localparam logic       DIR_UP         = 1'b0;

endpackage : hall_mcm_pkg

// ===== verif/hall_sensor_model.sv
// Purpose: Hall sensor levels at the position inputs
// Assumes: Bench sets the target level pattern
// Notes:   Levels follow the target one clock later
`timescale 1ns/100ps
module hall_sensor_model (
  input  wire logic       pclk,
  input  wire logic [2:0] target,
  output logic      [2:0] position_input
);
  initial position_input = 3'h0;
  always @(posedge pclk) begin
    position_input <= target;
  end
endmodule : hall_sensor_model

// ===== verif/tb_hall_multichannel_pattern_switch.sv
// Purpose: Self-checking bench for the pattern switch
// Assumes: Zero-wait APB slave, timer events as pulses
// Notes:   Pulse outputs counted over the whole run
`timescale 1ns/100ps
module tb_hall_multichannel_pattern_switch;
  import hall_mcm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, dir, pready, err, perr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [2:0]  target, pos, cur;
  logic [5:0]  aop, p, q;
  logic [6:0]  ev;
  logic        st, che, whe, rdy, blk;
  int          fails, num_checks, w, r;
  int          num_st, num_che, num_whe, num_rdy;
  int          tbit[4] = '{0, 4, 6, 3};
  logic        tdir[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  hall_sensor_model hall_sensor_model_i (.pclk(pclk), .target(target), .position_input(pos));
  hall_pattern_switch hall_pattern_switch_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(perr), .position_input(pos), .aux_period_match(ev[0]),
    .aux_zero_match(ev[1]), .aux_compare_match(ev[2]), .main_period_match(ev[3]),
    .main_one_match(ev[4]), .main_zero_match(ev[5]), .channel1_compare_match(ev[6]),
    .count_direction(dir), .active_output_pattern(aop), .hall_compare_ready(rdy),
    .correct_hall_event(che), .wrong_hall_event(whe), .pattern_shadow_transfer(st),
    .main_pwm_blocked(blk));
  // ----------------------------------------------------------------
  // Pulse counters
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      num_st  <= num_st + int'(st);
      num_che <= num_che + int'(che);
      num_whe <= num_whe + int'(whe);
      num_rdy <= num_rdy + int'(rdy);
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) fails++;
    @(posedge pclk);
  endtask : apb
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev <= 7'h0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  task automatic test_done();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    test_done();
  end
  initial begin
    seed = 32'ha1149bf5;
    {presetn, psel, penable, pwrite, dir, paddr, pwdata, ev, target} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(aop), 32'h0);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    check(rd, CTRL_RESET);
    apb(1'b0, ACTIVE_OFFSET, 32'h0);
    check(rd, PATTERN_RESET);
    apb(1'b0, 8'h40, 32'h0);
    check(32'(err), 32'h1);
    for (int i = 0; i < 3; i++) begin
      q = 6'($random(seed));
      apb(1'b1, SHADOW_OFFSET, {15'h0, 1'b1, 10'h0, q});
      check(32'(aop), 32'(q));
      apb(1'b0, STATUS_OFFSET, 32'h0);
      check(32'(rd[4]), 32'h1);
      apb(1'b1, STATUS_OFFSET, 32'h10);
    end
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, CTRL_OFFSET, (k == 0) ? 32'h1000 : 32'h1005 + 32'(k));
      apb(1'b1, SHADOW_OFFSET, {26'h0, ~q});
      for (int b = 0; b < 7; b++) pulse(b);
      check(32'(aop), 32'(q));
    end
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, CTRL_OFFSET, 32'h1002 + 32'(k));
      p = 6'($random(seed));
      apb(1'b1, SHADOW_OFFSET, {26'h0, p});
      if (k > 0) begin
        dir <= ~tdir[k];
        pulse(tbit[k]);
        check(32'(aop), 32'(q));
      end
      dir <= tdir[k];
      pulse(tbit[k]);
      check(32'(aop), 32'(p));
      q = p;
    end
    cur = 3'($random(seed));
    target <= cur;
    apb(1'b1, CTRL_OFFSET, 32'h1001);
    apb(1'b1, SHADOW_OFFSET, {14'h0, 1'b1, 3'h0, cur ^ 3'h1, cur, 2'h0, q});
    q = ~q;
    apb(1'b1, SHADOW_OFFSET, {18'h0, cur ^ 3'h3, cur ^ 3'h1, 2'h0, q});
    target <= cur ^ 3'h1;
    repeat (6) @(posedge pclk);
    check(32'(aop), 32'(q));
    apb(1'b0, ACTIVE_OFFSET, 32'h0);
    check(32'(rd[13:8]), 32'({cur ^ 3'h3, cur ^ 3'h1}));
    apb(1'b1, STATUS_OFFSET, 32'h60);
    target <= cur ^ 3'h5;
    repeat (6) @(posedge pclk);
    target <= cur ^ 3'h1;
    repeat (6) @(posedge pclk);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check(32'({rd[6:5], aop}), 32'({2'b10, q}));
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, CTRL_OFFSET, 32'h1002 | 32'(s << 4));
      p = ~q;
      apb(1'b1, SHADOW_OFFSET, {26'h0, p});
      pulse(0);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      check(32'({rd[3], aop}), 32'({1'b1, q}));
      w = (s == 1) ? 5 : 1;
      r = (s == 2) ? 5 : 1;
      pulse(w);
      check(32'(aop), 32'((s == 3) ? q : ((s == 2) ? q : q)));
      pulse(r);
      if (s < 3) q = p;
      check(32'(aop), 32'(q));
    end
    apb(1'b1, CTRL_OFFSET, 32'h1300);
    target <= cur ^ 3'h7;
    repeat (6) @(posedge pclk);
    check(32'(aop), {26'h0, ~q});
    apb(1'b1, DEADTIME_OFFSET, 32'h2);
    apb(1'b1, CTRL_OFFSET, 32'h0888_0001);
    q = ~q ^ 6'h0f;
    apb(1'b1, SHADOW_OFFSET, {26'h0, q});
    target <= cur ^ 3'h3;
    repeat (10) @(posedge pclk);
    check(32'(aop), 32'(q));
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check(32'({blk, rd[7]}), 32'h3);
    check(32'(num_st), 32'hc);
    check(32'(num_che), 32'h2);
    check(32'(num_whe), 32'(cur != 3'h0) + 32'h1);
    check(32'(num_rdy), 32'(cur != 3'h0) + 32'h4);
    test_done();
  end
endmodule : tb_hall_multichannel_pattern_switch
